// ---- src/pit_pkg.sv ----
// shared constants for the periodic interrupt tick and its processor bus
package pit_pkg;
	localparam int unsigned CLK_HZ     = 100_000_000;
	localparam int unsigned E_HZ       = 1_000_000;
	localparam int unsigned E_DIV      = CLK_HZ / E_HZ;
	localparam int unsigned TICK_DIV   = 1000;
	localparam int unsigned TICK_HZ    = E_HZ / TICK_DIV;
	localparam int unsigned HOLD_S     = 1;
	localparam int unsigned HOLD_TICKS = HOLD_S * TICK_HZ;
	localparam int unsigned IRQ_LOW_E  = 4;

	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DEC_W  = 15;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned TICK_W = 10;
	localparam int unsigned LOW_W  = 4;
	localparam int unsigned HOLD_W = 11;
	localparam int unsigned EDIV_W = 8;

	localparam logic [ADDR_W-1:0] ADDR_SOL  = 16'h2000;
	localparam logic [ADDR_W-1:0] ADDR_AUX  = 16'h2001;
	localparam logic [ADDR_W-1:0] ADDR_SW   = 16'h3000;
	localparam logic [ADDR_W-1:0] ADDR_VEC  = 16'h7ff8;
	localparam logic [DATA_W-1:0] BUS_IDLE  = 8'hff;
	localparam logic [DATA_W-1:0] PORT_RST  = 8'h00;

	typedef enum logic [1:0] {
		PIT_H_IDLE = 2'b00,
		PIT_H_ACC  = 2'b01
	} pit_hstate_t;
endpackage

// ---- src/pit_bus_if.sv ----
// processor bus between the tick device and the processor end
`timescale 1ns/1ps
`default_nettype none
interface pit_bus_if;
	logic                        e_clk;
	logic                        sel;
	logic                        rw;
	logic [pit_pkg::ADDR_W-1:0]  addr;
	logic [pit_pkg::DATA_W-1:0]  h2d;
	logic                        h_oe;
	logic [pit_pkg::DATA_W-1:0]  d2h;
	logic                        d_oe;
	logic [pit_pkg::DATA_W-1:0]  data;
	logic                        irq_n;
	logic                        play_en;

	// wire level of the shared data lines, pulled up when nobody drives
	assign data = d_oe ? d2h : (h_oe ? h2d : pit_pkg::BUS_IDLE);

	modport host (
		output e_clk, sel, rw, addr, h2d, h_oe, play_en,
		input  data, irq_n
	);
	modport dev (
		input  e_clk, sel, rw, addr, data, play_en,
		output d2h, d_oe, irq_n
	);
endinterface
`default_nettype wire

// ---- src/pit_dev_end.sv ----
// device end: 1 ms interrupt tick, peripheral ports, play gating, ram protect
// Function
// (R1) count 1000 bus clocks per tick period
// (R2) tick drives maskable interrupt at 1 kHz
// (R3) interrupt request active low once per millisecond
// (R4) processor fetches two-byte vector from rom
// (R5) decode only low fifteen address lines
// (R6) eight-bit bidirectional data, single driver
// (R7) write: select, rw low, address, then data
// (R8) written port updates its outputs
// (R9) switch read: 1 closed, 0 open
// (R10) special solenoids, flippers only with play enable
// (R11) protect high one second, then enable pulses
// (R12) ram enable and write pulse while idle
// (R13) divider reloads at terminal count, no drift
// (R14) request low fixed cycles, then high
`timescale 1ns/1ps
`default_nettype none
module pit_dev_end #(
	parameter int unsigned TICK_CNT   = pit_pkg::TICK_DIV,
	parameter int unsigned IRQ_LOW    = pit_pkg::IRQ_LOW_E,
	parameter int unsigned HOLD_CNT   = pit_pkg::HOLD_TICKS
) (
	input  wire logic                        i_mclk,
	input  wire logic                        i_sys_rst,
	pit_bus_if.dev                           bus,
	input  wire logic [pit_pkg::DATA_W-1:0]  i_switch,
	input  wire logic [pit_pkg::DATA_W-1:0]  i_special_sw,
	input  wire logic [1:0]                  i_flip_btn,
	output logic      [pit_pkg::DATA_W-1:0]  o_solenoid,
	output logic      [pit_pkg::DATA_W-1:0]  o_aux,
	output logic      [pit_pkg::DATA_W-1:0]  o_special,
	output logic      [1:0]                  o_flipper,
	output logic                             o_bram_protect,
	output logic                             o_bram_en,
	output logic                             o_bram_wr
);
	import pit_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// address decode on the low lines only

	function automatic logic addr_hit(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] t
	);
		addr_hit = (a[DEC_W-1:0] == t[DEC_W-1:0]);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	logic                e_prev_reg;
	logic                e_prev_next;
	logic [TICK_W-1:0]   tick_reg;
	logic [TICK_W-1:0]   tick_next;
	logic [LOW_W-1:0]    low_reg;
	logic [LOW_W-1:0]    low_next;
	logic                irq_n_reg;
	logic                irq_n_next;
	logic [HOLD_W-1:0]   hold_reg;
	logic [HOLD_W-1:0]   hold_next;
	logic                prot_reg;
	logic                prot_next;
	logic                ben_reg;
	logic                ben_next;
	logic                bwr_reg;
	logic                bwr_next;
	logic [DATA_W-1:0]   sol_reg;
	logic [DATA_W-1:0]   sol_next;
	logic [DATA_W-1:0]   aux_reg;
	logic [DATA_W-1:0]   aux_next;
	logic [DATA_W-1:0]   dout_reg;
	logic [DATA_W-1:0]   dout_next;
	logic                doe_reg;
	logic                doe_next;
	logic [DATA_W-1:0]   spec_reg;
	logic [DATA_W-1:0]   spec_next;
	logic [1:0]          flip_reg;
	logic [1:0]          flip_next;
	logic                e_rise;
	logic                e_fall;
	logic                wr_cyc;
	logic                rd_cyc;

	assign e_rise = bus.e_clk & ~e_prev_reg;
	assign e_fall = ~bus.e_clk & e_prev_reg;
	assign wr_cyc = e_fall & bus.sel & ~bus.rw;
	assign rd_cyc = bus.sel & bus.rw;

	////////////////////////////////////////////////////////////////////////
	// interrupt divider and hold timer

	always_comb
	begin
		e_prev_next = bus.e_clk;
		tick_next   = tick_reg;
		low_next    = low_reg;
		irq_n_next  = irq_n_reg;
		hold_next   = hold_reg;
		if (e_rise)
		begin
			if (!irq_n_reg)
			begin
				low_next = low_reg - 1'b1;
				if (low_reg == LOW_W'(1))
					irq_n_next = 1'b1; // [R14]
			end
			if (tick_reg == TICK_W'(TICK_CNT - 1))
			begin
				tick_next  = '0; // [R1] [R13]
				irq_n_next = 1'b0; // [R2] [R3]
				low_next   = LOW_W'(IRQ_LOW); // [R14]
				if (hold_reg != HOLD_W'(HOLD_CNT))
					hold_next = hold_reg + 1'b1; // [R11]
			end
			else
				tick_next = tick_reg + 1'b1; // [R1]
		end
		prot_next = (hold_next != HOLD_W'(HOLD_CNT)); // [R11]
		// ram strobes follow the bus clock once the hold is over, the write strobe only outside read cycles
		ben_next  = ~prot_reg & bus.e_clk; // [R11] [R12]
		bwr_next  = ~prot_reg & bus.e_clk & ~rd_cyc; // [R12]
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			e_prev_reg <= 1'b0;
			tick_reg   <= '0;
			low_reg    <= '0;
			irq_n_reg  <= 1'b1;
			hold_reg   <= '0;
			prot_reg   <= 1'b1;
			ben_reg    <= 1'b0;
			bwr_reg    <= 1'b0;
		end
		else
		begin
			e_prev_reg <= e_prev_next;
			tick_reg   <= tick_next;
			low_reg    <= low_next;
			irq_n_reg  <= irq_n_next;
			hold_reg   <= hold_next;
			prot_reg   <= prot_next;
			ben_reg    <= ben_next;
			bwr_reg    <= bwr_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// peripheral ports and play gating

	always_comb
	begin
		sol_next  = sol_reg;
		aux_next  = aux_reg;
		dout_next = dout_reg;
		doe_next  = 1'b0;
		// write data is taken as the bus clock falls
		if (wr_cyc && addr_hit(bus.addr, ADDR_SOL))
			sol_next = bus.data; // [R5] [R7] [R8]
		if (wr_cyc && addr_hit(bus.addr, ADDR_AUX))
			aux_next = bus.data; // [R5] [R8]
		if (rd_cyc && addr_hit(bus.addr, ADDR_SW))
		begin
			doe_next  = 1'b1; // [R6]
			dout_next = i_switch; // [R9]
		end
		else if (rd_cyc && addr_hit(bus.addr, ADDR_SOL))
		begin
			doe_next  = 1'b1; // [R6]
			dout_next = sol_reg;
		end
		else if (rd_cyc && addr_hit(bus.addr, ADDR_AUX))
		begin
			doe_next  = 1'b1; // [R6]
			dout_next = aux_reg;
		end
		spec_next = bus.play_en ? i_special_sw : '0; // [R10]
		flip_next = bus.play_en ? i_flip_btn : 2'h0; // [R10]
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			sol_reg  <= PORT_RST;
			aux_reg  <= PORT_RST;
			dout_reg <= PORT_RST;
			doe_reg  <= 1'b0;
			spec_reg <= '0;
			flip_reg <= 2'h0;
		end
		else
		begin
			sol_reg  <= sol_next;
			aux_reg  <= aux_next;
			dout_reg <= dout_next;
			doe_reg  <= doe_next;
			spec_reg <= spec_next;
			flip_reg <= flip_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign bus.irq_n      = irq_n_reg;
	assign bus.d2h        = dout_reg;
	assign bus.d_oe       = doe_reg;
	assign o_solenoid     = sol_reg;
	assign o_aux          = aux_reg;
	assign o_special      = spec_reg;
	assign o_flipper      = flip_reg;
	assign o_bram_protect = prot_reg;
	assign o_bram_en      = ben_reg;
	assign o_bram_wr      = bwr_reg;
endmodule
`default_nettype wire

// ---- src/pit_host_end.sv ----
// processor end: bus clock, port accesses, interrupt vector fetch
`timescale 1ns/1ps
`default_nettype none
module pit_host_end #(
	parameter int unsigned E_CNT = pit_pkg::E_DIV
) (
	input  wire logic                        i_mclk,
	input  wire logic                        i_sys_rst,
	pit_bus_if.host                          bus,
	input  wire logic                        i_cmd_valid,
	input  wire logic                        i_cmd_write,
	input  wire logic [pit_pkg::ADDR_W-1:0]  i_cmd_addr,
	input  wire logic [pit_pkg::DATA_W-1:0]  i_cmd_wdata,
	input  wire logic                        i_play_en,
	output logic                             o_cmd_ready,
	output logic                             o_rd_valid,
	output logic      [pit_pkg::DATA_W-1:0]  o_rd_data,
	output logic                             o_vec_valid,
	output logic      [15:0]                 o_vector
);
	import pit_pkg::*;

	localparam logic [EDIV_W-1:0] E_LAST  = EDIV_W'(E_CNT - 1);
	localparam logic [EDIV_W-1:0] E_HALF  = EDIV_W'(E_CNT / 2);
	localparam logic [EDIV_W-1:0] E_START = 8'h01;

	pit_hstate_t        st_reg, st_next;
	logic [EDIV_W-1:0]  ecnt_reg, ecnt_next;
	logic               eclk_reg, eclk_next;
	logic               sel_reg, sel_next;
	logic               rw_reg, rw_next;
	logic [ADDR_W-1:0]  addr_reg, addr_next;
	logic [DATA_W-1:0]  wd_reg, wd_next;
	logic               oe_reg, oe_next;
	logic               play_reg, play_next;
	logic               irqp_reg, irqp_next;
	logic               vpend_reg, vpend_next;
	logic               vidx_reg, vidx_next;
	logic               avec_reg, avec_next;
	logic               cfull_reg, cfull_next;
	logic               cwr_reg, cwr_next;
	logic [ADDR_W-1:0]  caddr_reg, caddr_next;
	logic [DATA_W-1:0]  cwd_reg, cwd_next;
	logic               rdv_reg, rdv_next;
	logic [DATA_W-1:0]  rdd_reg, rdd_next;
	logic               vv_reg, vv_next;
	logic [15:0]        vec_reg, vec_next;

	always_comb
	begin
		st_next    = st_reg;
		ecnt_next  = (ecnt_reg == E_LAST) ? '0 : ecnt_reg + 1'b1;
		eclk_next  = (ecnt_next >= E_HALF);
		sel_next   = sel_reg;
		rw_next    = rw_reg;
		addr_next  = addr_reg;
		wd_next    = wd_reg;
		oe_next    = oe_reg;
		play_next  = i_play_en;
		irqp_next  = bus.irq_n;
		vpend_next = vpend_reg;
		vidx_next  = vidx_reg;
		avec_next  = avec_reg;
		cfull_next = cfull_reg;
		cwr_next   = cwr_reg;
		caddr_next = caddr_reg;
		cwd_next   = cwd_reg;
		rdv_next   = 1'b0;
		rdd_next   = rdd_reg;
		vv_next    = 1'b0;
		vec_next   = vec_reg;
		if (o_cmd_ready && i_cmd_valid)
		begin
			cfull_next = 1'b1;
			cwr_next   = i_cmd_write;
			caddr_next = i_cmd_addr;
			cwd_next   = i_cmd_wdata;
		end
		case (st_reg)
			PIT_H_IDLE:
				if (ecnt_reg == E_START && (vpend_reg || vidx_reg))
				begin
					// vector fetch: high byte first, two reads
					st_next    = PIT_H_ACC;
					sel_next   = 1'b1;
					rw_next    = 1'b1;
					addr_next  = ADDR_VEC | {15'h0000, vidx_reg}; // [R4]
					avec_next  = 1'b1;
					vpend_next = 1'b0;
				end
				else if (ecnt_reg == E_START && cfull_reg)
				begin
					st_next    = PIT_H_ACC;
					sel_next   = 1'b1; // [R7]
					rw_next    = ~cwr_reg; // [R7]
					addr_next  = caddr_reg; // [R5] [R7]
					wd_next    = cwd_reg;
					avec_next  = 1'b0;
				end
			PIT_H_ACC:
			begin
				if (ecnt_reg == E_HALF - 1'b1 && !rw_reg)
					oe_next = 1'b1; // [R6] [R7]
				if (ecnt_reg == '0)
				begin
					st_next  = PIT_H_IDLE;
					sel_next = 1'b0;
					oe_next  = 1'b0;
					rw_next  = 1'b1;
					if (avec_reg)
					begin
						vidx_next = ~vidx_reg;
						if (vidx_reg)
						begin
							vec_next[7:0] = bus.data; // [R4]
							vv_next       = 1'b1;
						end
						else
							vec_next[15:8] = bus.data; // [R4]
					end
					else
					begin
						cfull_next = 1'b0;
						rdv_next   = rw_reg;
						if (rw_reg)
							rdd_next = bus.data;
					end
				end
			end
			default:
				st_next = PIT_H_IDLE;
		endcase
		// request edge wins over the clear of the pending flag
		if (irqp_reg && !bus.irq_n)
			vpend_next = 1'b1; // [R2]
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			st_reg    <= PIT_H_IDLE;
			ecnt_reg  <= '0;
			eclk_reg  <= 1'b0;
			sel_reg   <= 1'b0;
			rw_reg    <= 1'b1;
			addr_reg  <= '0;
			wd_reg    <= '0;
			oe_reg    <= 1'b0;
			play_reg  <= 1'b0;
			irqp_reg  <= 1'b1;
			vpend_reg <= 1'b0;
			vidx_reg  <= 1'b0;
			avec_reg  <= 1'b0;
			cfull_reg <= 1'b0;
			cwr_reg   <= 1'b0;
			caddr_reg <= '0;
			cwd_reg   <= '0;
			rdv_reg   <= 1'b0;
			rdd_reg   <= '0;
			vv_reg    <= 1'b0;
			vec_reg   <= 16'h0000;
			o_cmd_ready <= 1'b0;
		end
		else
		begin
			st_reg    <= st_next;
			ecnt_reg  <= ecnt_next;
			eclk_reg  <= eclk_next;
			sel_reg   <= sel_next;
			rw_reg    <= rw_next;
			addr_reg  <= addr_next;
			wd_reg    <= wd_next;
			oe_reg    <= oe_next;
			play_reg  <= play_next;
			irqp_reg  <= irqp_next;
			vpend_reg <= vpend_next;
			vidx_reg  <= vidx_next;
			avec_reg  <= avec_next;
			cfull_reg <= cfull_next;
			cwr_reg   <= cwr_next;
			caddr_reg <= caddr_next;
			cwd_reg   <= cwd_next;
			rdv_reg   <= rdv_next;
			rdd_reg   <= rdd_next;
			vv_reg    <= vv_next;
			vec_reg   <= vec_next;
			o_cmd_ready <= ~cfull_next;
		end
	end

	assign bus.e_clk   = eclk_reg;
	assign bus.sel     = sel_reg;
	assign bus.rw      = rw_reg;
	assign bus.addr    = addr_reg;
	assign bus.h2d     = wd_reg;
	assign bus.h_oe    = oe_reg;
	assign bus.play_en = play_reg;
	assign o_rd_valid  = rdv_reg;
	assign o_rd_data   = rdd_reg;
	assign o_vec_valid = vv_reg;
	assign o_vector    = vec_reg;
endmodule
`default_nettype wire

// ---- test/pit_bus_checker.sv ----
// concurrent checks on the processor bus between both ends
`timescale 1ns/1ps
`default_nettype none
module pit_bus_checker #(
	parameter int unsigned TICK_CNT = 10,
	parameter int unsigned IRQ_LOW  = 2
) (
	input  wire logic                        i_mclk,
	input  wire logic                        i_sys_rst,
	input  wire logic                        e_clk,
	input  wire logic                        sel,
	input  wire logic                        rw,
	input  wire logic [pit_pkg::ADDR_W-1:0]  addr,
	input  wire logic                        h_oe,
	input  wire logic                        d_oe,
	input  wire logic                        irq_n
);
	import pit_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic        e_prev_reg;
	logic        e_prev_next;
	logic        irq_prev_reg;
	logic        irq_prev_next;
	int unsigned rise_reg;
	int unsigned rise_next;
	logic        e_rise;
	logic        irq_fall;
	logic        rd_hit;
	logic        wr_on;

	// bus clock rises counted since the last request fall
	always_comb
	begin
		e_rise = e_clk && !e_prev_reg;
		irq_fall = irq_prev_reg && !irq_n;
		rd_hit = sel && rw && (addr[14:0] == ADDR_SOL[14:0] || addr[14:0] == ADDR_AUX[14:0]
			|| addr[14:0] == ADDR_SW[14:0]);
		wr_on = sel && !rw;
		e_prev_next = e_clk;
		irq_prev_next = irq_n;
		rise_next = rise_reg;
		if (irq_fall)
			rise_next = 0;
		else if (e_rise)
			rise_next = rise_reg + 1;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			e_prev_reg <= 1'b0;
			irq_prev_reg <= 1'b1;
			rise_reg <= 0;
		end
		else
		begin
			e_prev_reg <= e_prev_next;
			irq_prev_reg <= irq_prev_next;
			rise_reg <= rise_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	sequence e_high_s;
		e_clk [*4];
	endsequence
	sequence e_low_s;
		!e_clk [*4];
	endsequence

	no_contention_a: assert property (!(d_oe && h_oe))
		else $error("both ends drive the data lines");
	rd_drive_cause_a: assert property ($rose(d_oe) |-> $past(rd_hit))
		else $error("device drove data without a mapped read");
	e_clk_shape_a: assert property ($rose(e_clk) |-> e_high_s ##1 e_low_s ##1 e_clk)
		else $error("bus clock period wrong");
	irq_period_a: assert property (irq_fall |-> rise_reg == TICK_CNT)
		else $error("request period not tick count");
	irq_width_a: assert property ($rose(irq_n) |-> rise_reg == IRQ_LOW)
		else $error("request low width wrong");
	irq_low_bound_a: assert property (!irq_n && !irq_fall |-> rise_reg <= IRQ_LOW)
		else $error("request held low too long");
	tick_overrun_a: assert property (rise_reg <= TICK_CNT)
		else $error("request missing after full period");
	access_hold_a: assert property (sel && $past(sel) |-> $stable(addr) && $stable(rw))
		else $error("address or direction moved in access");
	wr_drive_order_a: assert property (h_oe |-> wr_on && $past(wr_on))
		else $error("write data driven before select");
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench joining the processor end and the tick device
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pit_pkg::*;
	localparam int unsigned TICKS = 10;
	localparam int unsigned E_N   = 8;
	localparam int unsigned LOW_N = 2;
	localparam int unsigned HOLD_N = 3;

	logic        i_mclk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        cmd_valid = 1'b0;
	logic        cmd_write = 1'b0;
	logic [15:0] cmd_addr = 16'h0000;
	logic [7:0]  cmd_wdata = 8'h00;
	logic        play = 1'b0;
	logic [7:0]  sw = 8'h00;
	logic [7:0]  spec = 8'h00;
	logic [1:0]  flip = 2'h0;
	logic        cmd_ready, rd_valid, vec_valid, prot, ben, bwr;
	logic [7:0]  rd_data, sol, aux, special;
	logic [1:0]  flipper;
	logic [15:0] vec;
	int          failures = 0;
	int          check_count = 0;
	int          cyc = 0;

	pit_bus_if bus();
	pit_dev_end #(.TICK_CNT(TICKS), .IRQ_LOW(LOW_N), .HOLD_CNT(HOLD_N)) pit_dev_end_inst (
		.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(bus), .i_switch(sw),
		.i_special_sw(spec), .i_flip_btn(flip), .o_solenoid(sol), .o_aux(aux),
		.o_special(special), .o_flipper(flipper), .o_bram_protect(prot),
		.o_bram_en(ben), .o_bram_wr(bwr));
	pit_host_end #(.E_CNT(E_N)) pit_host_end_inst (
		.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(bus), .i_cmd_valid(cmd_valid),
		.i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata),
		.i_play_en(play), .o_cmd_ready(cmd_ready), .o_rd_valid(rd_valid),
		.o_rd_data(rd_data), .o_vec_valid(vec_valid), .o_vector(vec));
	pit_bus_checker #(.TICK_CNT(TICKS), .IRQ_LOW(LOW_N)) pit_bus_checker_inst (
		.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .e_clk(bus.e_clk), .sel(bus.sel),
		.rw(bus.rw), .addr(bus.addr), .h_oe(bus.h_oe), .d_oe(bus.d_oe), .irq_n(bus.irq_n));

	always #5 i_mclk = ~i_mclk;

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (failures == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge i_mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			failures++;
			give_verdict();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge i_mclk);
			#1;
		end
	endtask

	// hold the command until ready is sampled, then wait for its bus access
	task automatic bus_op(input logic w, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		cmd_wdata = d;
		while (cmd_ready !== 1'b1)
			tick(1);
		tick(1);
		cmd_valid = 1'b0;
		q = 8'h00;
		if (w)
		begin
			while (!(bus.sel === 1'b1 && bus.rw === 1'b0))
				tick(1);
			while (bus.sel !== 1'b0)
				tick(1);
			tick(2);
		end
		else
		begin
			while (rd_valid !== 1'b1)
				tick(1);
			q = rd_data;
		end
	endtask

	// cycles until the request next goes low
	task automatic wait_fall(output int n);
		n = 0;
		while (bus.irq_n !== 1'b1)
		begin
			tick(1);
			n++;
		end
		while (bus.irq_n !== 1'b0)
		begin
			tick(1);
			n++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_hold();
		int   n;
		int   k_en;
		int   k_wr;
		logic p_en;
		logic p_wr;
		chk("protect", 16'h1, {15'h0000, prot});
		repeat (HOLD_N - 1)
		begin
			wait_fall(n);
			chk("protect", 16'h1, {15'h0000, prot});
		end
		wait_fall(n);
		chk("protect", 16'h0, {15'h0000, prot});
		// count strobes only once the vector reads are over
		while (vec_valid !== 1'b1)
			tick(1);
		k_en = 0;
		k_wr = 0;
		p_en = ben;
		p_wr = bwr;
		repeat (4 * E_N)
		begin
			tick(1);
			k_en += (ben === 1'b1 && p_en === 1'b0);
			k_wr += (bwr === 1'b1 && p_wr === 1'b0);
			p_en = ben;
			p_wr = bwr;
		end
		chk("ram enable pulses", 16'h4, k_en[15:0]);
		chk("ram write pulses", 16'h4, k_wr[15:0]);
	endtask

	task automatic t_period();
		int n;
		wait_fall(n);
		wait_fall(n);
		chk("request period", 16'(TICKS * E_N), n[15:0]);
		n = 0;
		while (bus.irq_n === 1'b0)
		begin
			tick(1);
			n++;
		end
		chk("request low time", 16'(LOW_N * E_N), n[15:0]);
		while (vec_valid !== 1'b1)
			tick(1);
		chk("vector", 16'hffff, vec);
	endtask

	task automatic t_gate();
		spec = 8'hff;
		flip = 2'h3;
		tick(4);
		chk("special idle", 16'h0, {8'h00, special});
		chk("flipper idle", 16'h0, {14'h0, flipper});
		play = 1'b1;
		tick(4);
		chk("special play", 16'hff, {8'h00, special});
		chk("flipper play", 16'h3, {14'h0, flipper});
		spec = 8'h0f;
		flip = 2'h1;
		tick(3);
		chk("special follow", 16'h0f, {8'h00, special});
		chk("flipper follow", 16'h1, {14'h0, flipper});
		play = 1'b0;
		tick(4);
		chk("special off", 16'h0, {8'h00, special});
	endtask

	task automatic t_ports();
		logic [7:0] q;
		bus_op(1'b1, ADDR_SOL, 8'ha5, q);
		chk("solenoid", 16'ha5, {8'h00, sol});
		bus_op(1'b1, ADDR_AUX, 8'h3c, q);
		chk("aux", 16'h3c, {8'h00, aux});
		bus_op(1'b0, ADDR_SOL, 8'h00, q);
		chk("solenoid read", 16'ha5, {8'h00, q});
		bus_op(1'b1, ADDR_SOL | 16'h8000, 8'h5a, q);
		chk("solenoid alias", 16'h5a, {8'h00, sol});
		bus_op(1'b1, 16'h4000, 8'hff, q);
		chk("unmapped write", 16'h5a3c, {sol, aux});
		sw = 8'h81;
		bus_op(1'b0, ADDR_SW, 8'h00, q);
		chk("switch read", 16'h81, {8'h00, q});
		sw = 8'h7e;
		bus_op(1'b0, ADDR_SW | 16'h8000, 8'h00, q);
		chk("switch alias", 16'h7e, {8'h00, q});
		bus_op(1'b0, 16'h4000, 8'h00, q);
		chk("unmapped read", 16'hff, {8'h00, q});
	endtask

	task automatic t_rereset();
		int n;
		i_sys_rst = 1'b1;
		tick(16);
		i_sys_rst = 1'b0;
		chk("protect again", 16'h1, {15'h0000, prot});
		chk("port cleared", 16'h0, {sol, aux});
		wait_fall(n);
		// bus clock first rises half a period after reset, seen a cycle later
		chk("first period", 16'((TICKS - 1) * E_N + E_N / 2 + 1), n[15:0]);
		chk("protect held", 16'h1, {15'h0000, prot});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		tick(16);
		i_sys_rst = 1'b0;
		t_hold();
		t_period();
		t_gate();
		t_ports();
		t_rereset();
		give_verdict();
	end
endmodule
`default_nettype wire
